/* File: eli_blinker.sv */
/*
  Blink generator: turns a selected pattern into the LED level using a
  millisecond prescaler on the system clock.
  Assumes pattern changes restart the timing.
*/
`timescale 1ns/1ps
module eli_blinker
  import eli_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     nrst,
  // Pattern in, level out
  input  eli_pat_e      pat,
  output logic          led
);

  logic [PRE_W-1:0] pre_reg;
  logic             tick;
  logic [MS_W-1:0]  ms_reg;
  logic [MS_W-1:0]  period;
  eli_pat_e         last_reg;
  logic             led_next;
  logic             wrap;

  assign tick = (pre_reg == PRE_W'(TICK_CYCLES - 1));

  // Half period, or full slow cycle length
  always_comb begin
    unique case (pat)
      PAT_FAST:   period = MS_W'(FAST_MS);
      PAT_NORMAL: period = MS_W'(NORMAL_MS);
      PAT_SLOW:   period = MS_W'(SLOW_ON_MS + SLOW_OFF_MS);
      default:    period = MS_W'(1);
    endcase
  end

  assign wrap = tick && (ms_reg == period - MS_W'(1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else if (tick || pat != last_reg) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ms_reg   <= '0;
      last_reg <= PAT_OFF;
    end else begin
      last_reg <= pat;
      if (pat != last_reg || wrap) begin
        ms_reg <= '0;
      end else if (tick) begin
        ms_reg <= ms_reg + MS_W'(1);
      end
    end
  end

  // Toggle patterns flip each interval; slow is a 1 s on, 3 s off cycle
  always_comb begin
    unique case (pat)
      PAT_ON:     led_next = 1'b1;
      PAT_FAST:   led_next = (pat != last_reg) ? 1'b1 : led ^ wrap;
      PAT_NORMAL: led_next = (pat != last_reg) ? 1'b1 : led ^ wrap;
      PAT_SLOW:   led_next = (ms_reg < MS_W'(SLOW_ON_MS));
      default:    led_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led <= LED_RST;
    end else begin
      led <= led_next;
    end
  end

endmodule

/* File: eli_pkg.sv */
/*
  Package for the error LED indicator: error codes, LED patterns,
  dispositions and blink timing constants.
  Assumes a 125 MHz system clock.
*/
package eli_pkg;

  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned CODE_W        = 16;

  // Blink intervals in milliseconds
  localparam int unsigned FAST_MS       = 200;
  localparam int unsigned NORMAL_MS     = 500;
  localparam int unsigned SLOW_ON_MS    = 1000;
  localparam int unsigned SLOW_OFF_MS   = 3000;
  // Prescaler ticks once per millisecond
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_W          = 12;
  localparam int unsigned PRE_W         = 17;

  // Error codes
  localparam logic [15:0] CODE_NONE     = 16'h0000;
  localparam logic [15:0] CODE_SCAN_TO  = 16'h000A;
  localparam logic [15:0] CODE_PROG_DMG = 16'h000C;
  localparam logic [15:0] CODE_MEM_DENY = 16'h0010;
  localparam logic [15:0] CODE_ID_BAD   = 16'h0011;
  localparam logic [15:0] CODE_PWD_BAD  = 16'h0012;
  localparam logic [15:0] CODE_SYNTAX   = 16'h8105;
  localparam logic [15:0] CODE_EXE_LEN  = 16'h8106;
  localparam logic [15:0] CODE_SRC_LEN  = 16'h8107;
  localparam logic [15:0] CODE_SW_LO    = 16'h8000;
  localparam logic [15:0] CODE_SW_HI    = 16'h8FFF;

  // Number of error sources
  localparam int unsigned NSRC          = 10;
  localparam int unsigned SRC_W         = 10;

  // Source indices, fixed priority by index within a class
  localparam int unsigned S_SERIOUS     = 0;
  localparam int unsigned S_POWER       = 1;
  localparam int unsigned S_PROG_DMG    = 2;
  localparam int unsigned S_MEM_DENY    = 3;
  localparam int unsigned S_SYSPROG     = 4;
  localparam int unsigned S_WARN        = 5;
  localparam int unsigned S_ID_BAD      = 6;
  localparam int unsigned S_PWD_BAD     = 7;
  localparam int unsigned S_SILENT_WARN = 8;
  localparam int unsigned S_DOWNLOAD    = 9;

  // Download fault kinds
  localparam logic [1:0]  DL_SYNTAX     = 2'h0;
  localparam logic [1:0]  DL_EXE_LEN    = 2'h1;
  localparam logic [1:0]  DL_SRC_LEN    = 2'h2;
  localparam logic [1:0]  DL_OTHER      = 2'h3;

  // LED patterns, one-hot, ordered by severity
  typedef enum logic [4:0] {
    PAT_ON     = 5'h10,
    PAT_FAST   = 5'h08,
    PAT_NORMAL = 5'h04,
    PAT_SLOW   = 5'h02,
    PAT_OFF    = 5'h01
  } eli_pat_e;

  // Reset values
  localparam logic        LED_RST       = 1'b0;
  localparam logic        RUN_RST       = 1'b1;

endpackage

/* File: eli_top.sv */
/*
  Error status and indicator logic for a controller CPU module.
  Collects error sources, holds an error code, picks the LED pattern and
  the run or halt decision. Sources are synchronous level inputs; a
  clear pulse from firmware releases latched errors.
*/
`timescale 1ns/1ps

// Functional notes
// - LED shows exactly one of five patterns
// - Serious error: LED steadily on
// - Power or hardware fault: fast 0.2 s blink
// - System program error: normal 0.5 s blink
// - Warning: on 1 s, off 3 s
// - Silent warning: LED off, flags, configurable
// - Halt until severe error cleared
// - Generate and hold error code
// - Stop-class halts, continue-class keeps running
// - Program damaged: 000C, halt, normal blink
// - Memory access denied: 0010, halt, normal
// - Identifier mismatch: 0011, run, LED off
// - Password mismatch: 0012, run, LED off
// - Download syntax fault: code 8105
// - Execution code too long: code 8106
// - Source code too long: code 8107
// - 8000 to 8FFF for software link errors
module eli_top
  import eli_pkg::*;
(
  // Clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  NRST,
  // Error sources, levels
  input  wire logic                  SERIOUS_ERR,
  input  wire logic                  POWER_FAULT,
  input  wire logic                  PROG_DAMAGED,
  input  wire logic                  MEM_DENIED,
  input  wire logic                  SYSPROG_ERR,
  input  wire logic                  WARN_ERR,
  input  wire logic                  ID_MISMATCH,
  input  wire logic                  PWD_MISMATCH,
  input  wire logic                  SILENT_WARN,
  // Download fault, pulse with kind and raw code
  input  wire logic                  DL_FAULT,
  input  wire logic [1:0]            DL_KIND,
  input  wire logic [eli_pkg::CODE_W-1:0] DL_CODE,
  // Configuration
  input  wire logic                  WARN_EN,
  input  wire logic                  SILENT_EN,
  // Firmware clear pulse
  input  wire logic                  ERR_CLEAR,
  // Outputs
  output logic                       ERROR_LED,
  output logic                       CPU_RUN,
  output logic [eli_pkg::CODE_W-1:0] ERROR_CODE,
  output logic                       ERROR_VALID,
  output logic                       SPECIAL_AUX_RELAY,
  output logic [eli_pkg::CODE_W-1:0] SPECIAL_DATA_REG
);

  logic [SRC_W-1:0]  raw;
  logic [SRC_W-1:0]  latch_reg;
  logic [SRC_W-1:0]  latch_next;
  logic [CODE_W-1:0] dl_code_reg;
  logic [CODE_W-1:0] code_next;
  logic              halt_next;
  eli_pat_e          pat_reg;
  eli_pat_e          pat_next;
  logic              led_w;

  // Code for a download fault kind
  function automatic logic [CODE_W-1:0] dl_map(
    input logic [1:0]        kind,
    input logic [CODE_W-1:0] raw_code
  );
    unique case (kind)
      DL_SYNTAX:  dl_map = CODE_SYNTAX;
      DL_EXE_LEN: dl_map = CODE_EXE_LEN;
      DL_SRC_LEN: dl_map = CODE_SRC_LEN;
      default: begin
        // Other link faults are forced into the software range
        dl_map = (raw_code >= CODE_SW_LO && raw_code <= CODE_SW_HI)
                 ? raw_code : CODE_SW_HI;
      end
    endcase
  endfunction

  // Warning sources are masked by their enables; condition is configurable
  always_comb begin
    raw = '0;
    raw[S_SERIOUS]     = SERIOUS_ERR;
    raw[S_POWER]       = POWER_FAULT;
    raw[S_PROG_DMG]    = PROG_DAMAGED;
    raw[S_MEM_DENY]    = MEM_DENIED;
    raw[S_SYSPROG]     = SYSPROG_ERR;
    raw[S_WARN]        = WARN_ERR && WARN_EN;
    raw[S_ID_BAD]      = ID_MISMATCH;
    raw[S_PWD_BAD]     = PWD_MISMATCH;
    raw[S_SILENT_WARN] = SILENT_WARN && SILENT_EN;
    raw[S_DOWNLOAD]    = DL_FAULT;
  end

  // Errors latch until cleared; a source still active at the clear
  // stays set, so a halted CPU cannot restart over a live fault.
  assign latch_next = (ERR_CLEAR ? '0 : latch_reg) | raw;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      latch_reg <= '0;
    end else begin
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      dl_code_reg <= CODE_NONE;
    end else if (DL_FAULT) begin
      dl_code_reg <= dl_map(DL_KIND, DL_CODE);
    end
  end

  // Most severe pattern wins
  always_comb begin
    if (latch_next[S_SERIOUS]) begin
      pat_next = PAT_ON;
    end else if (latch_next[S_POWER]) begin
      pat_next = PAT_FAST;
    end else if (latch_next[S_PROG_DMG] || latch_next[S_MEM_DENY]
                 || latch_next[S_SYSPROG]) begin
      pat_next = PAT_NORMAL;
    end else if (latch_next[S_WARN]) begin
      pat_next = PAT_SLOW;
    end else begin
      pat_next = PAT_OFF;
    end
  end

  // Stop-class sources are the on, fast and normal classes
  assign halt_next = latch_next[S_SERIOUS] || latch_next[S_POWER]
                     || latch_next[S_PROG_DMG] || latch_next[S_MEM_DENY]
                     || latch_next[S_SYSPROG];

  // Code of the most severe latched coded error; power and system program errors give none
  always_comb begin
    if (latch_next[S_SERIOUS]) begin
      code_next = CODE_SCAN_TO;
    end else if (latch_next[S_PROG_DMG]) begin
      code_next = CODE_PROG_DMG;
    end else if (latch_next[S_MEM_DENY]) begin
      code_next = CODE_MEM_DENY;
    end else if (latch_next[S_ID_BAD]) begin
      code_next = CODE_ID_BAD;
    end else if (latch_next[S_PWD_BAD]) begin
      code_next = CODE_PWD_BAD;
    end else if (latch_next[S_DOWNLOAD]) begin
      code_next = DL_FAULT ? dl_map(DL_KIND, DL_CODE) : dl_code_reg;
    end else begin
      code_next = CODE_NONE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pat_reg <= PAT_OFF;
    end else begin
      pat_reg <= pat_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CPU_RUN <= RUN_RST;
    end else begin
      CPU_RUN <= !halt_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ERROR_CODE  <= CODE_NONE;
      ERROR_VALID <= 1'b0;
    end else begin
      ERROR_CODE  <= code_next;
      ERROR_VALID <= |latch_next;
    end
  end

  // Silent warnings are visible only through the flag outputs and ERROR_VALID, never on the LED
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      SPECIAL_AUX_RELAY <= 1'b0;
      SPECIAL_DATA_REG  <= CODE_NONE;
    end else begin
      SPECIAL_AUX_RELAY <= latch_next[S_SILENT_WARN]
                           || latch_next[S_WARN];
      SPECIAL_DATA_REG  <= CODE_W'(latch_next);
    end
  end

  eli_blinker u_blink (
    .clk  (SYS_CLK),
    .nrst (NRST),
    .pat  (pat_reg),
    .led  (led_w)
  );

  assign ERROR_LED = led_w;

endmodule

/* File: eli_top_asserts.sv */
/*
  Concurrent checks on the error indicator top level.
  Assumes binding to eli_top and sight of its ports only.
*/
`timescale 1ns/1ps
module eli_top_asserts
  import eli_pkg::*;
(
  // Clock and reset
  input wire logic                       SYS_CLK,
  input wire logic                       NRST,
  // Sources
  input wire logic                       SERIOUS_ERR,
  input wire logic                       POWER_FAULT,
  input wire logic                       PROG_DAMAGED,
  input wire logic                       MEM_DENIED,
  input wire logic                       SYSPROG_ERR,
  input wire logic                       ID_MISMATCH,
  input wire logic                       PWD_MISMATCH,
  input wire logic                       SILENT_WARN,
  input wire logic                       DL_FAULT,
  input wire logic                       SILENT_EN,
  input wire logic                       ERR_CLEAR,
  // Results
  input wire logic                       ERROR_LED,
  input wire logic                       CPU_RUN,
  input wire logic [eli_pkg::CODE_W-1:0] ERROR_CODE,
  input wire logic                       ERROR_VALID,
  input wire logic                       SPECIAL_AUX_RELAY,
  input wire logic [eli_pkg::CODE_W-1:0] SPECIAL_DATA_REG
);
  logic halt_src;

  assign halt_src = SERIOUS_ERR | POWER_FAULT | PROG_DAMAGED |
                    MEM_DENIED | SYSPROG_ERR;

  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  // Latch seen two cycles: the pattern stage has caught up with it
  sequence s_serious_held;
    SPECIAL_DATA_REG[S_SERIOUS] [*2];
  endsequence
  sequence s_quiet_held;
    ((SPECIAL_DATA_REG & 16'h023F) == 16'h0000) [*2];
  endsequence

  chk_serious_lit: assert property (s_serious_held |-> ERROR_LED)
    else $error("LED dark with serious error held");
  chk_quiet_dark: assert property (s_quiet_held |-> !ERROR_LED)
    else $error("LED lit with only quiet errors");
  chk_stop_holds: assert property (!CPU_RUN && !ERR_CLEAR |=> !CPU_RUN)
    else $error("CPU resumed without clear");
  chk_clear_release: assert property
    (ERR_CLEAR && !halt_src && !DL_FAULT |=> CPU_RUN)
    else $error("CPU still halted after clear");
  // A newly arriving coded source may outrank the held code, so only
  // quiet cycles are required to keep it
  chk_code_holds: assert property
    (ERROR_VALID && !ERR_CLEAR && !halt_src && !ID_MISMATCH
     && !PWD_MISMATCH && !DL_FAULT
     |=> ERROR_VALID && $stable(ERROR_CODE))
    else $error("Error code not held");
  chk_prog_halt: assert property
    (PROG_DAMAGED && !SERIOUS_ERR && !SPECIAL_DATA_REG[S_SERIOUS]
     |=> !CPU_RUN && ERROR_CODE == CODE_PROG_DMG)
    else $error("Program damage not reported");
  chk_mem_halt: assert property
    (MEM_DENIED |=> !CPU_RUN && SPECIAL_DATA_REG[S_MEM_DENY])
    else $error("Memory denial not reported");
  chk_id_runs: assert property
    (ID_MISMATCH && !halt_src && SPECIAL_DATA_REG[4:0] == 5'h00
     |=> CPU_RUN && ERROR_CODE == CODE_ID_BAD)
    else $error("Identifier mismatch mishandled");
  chk_silent_flag: assert property
    (SILENT_WARN && SILENT_EN
     |=> SPECIAL_AUX_RELAY && SPECIAL_DATA_REG[S_SILENT_WARN])
    else $error("Silent warning flag missing");
endmodule

bind eli_top eli_top_asserts chk_u (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .SERIOUS_ERR(SERIOUS_ERR),
  .POWER_FAULT(POWER_FAULT), .PROG_DAMAGED(PROG_DAMAGED),
  .MEM_DENIED(MEM_DENIED), .SYSPROG_ERR(SYSPROG_ERR),
  .ID_MISMATCH(ID_MISMATCH), .PWD_MISMATCH(PWD_MISMATCH),
  .SILENT_WARN(SILENT_WARN),
  .DL_FAULT(DL_FAULT), .SILENT_EN(SILENT_EN), .ERR_CLEAR(ERR_CLEAR),
  .ERROR_LED(ERROR_LED), .CPU_RUN(CPU_RUN), .ERROR_CODE(ERROR_CODE),
  .ERROR_VALID(ERROR_VALID), .SPECIAL_AUX_RELAY(SPECIAL_AUX_RELAY),
  .SPECIAL_DATA_REG(SPECIAL_DATA_REG));

/* File: test_error_led_indicator.sv */
/*
  Self-checking bench for the error indicator top level.
  Assumes the package constants; blink periods are too long to watch.
*/
`timescale 1ns/1ps
module test_error_led_indicator;
  import eli_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [9:0]  src = '0;
  logic [1:0]  dl_kind = 2'h0;
  logic [15:0] dl_code = 16'h0000;
  logic        warn_en = 1'b0;
  logic        silent_en = 1'b0;
  logic        clr = 1'b0;
  logic        led;
  logic        run;
  logic [15:0] code;
  logic        valid;
  logic        aux;
  logic [15:0] dreg;
  int          n_fail = 0;
  int          tests_run = 0;

  eli_top dut_u (.SYS_CLK(clk), .NRST(nrst), .SERIOUS_ERR(src[0]),
    .POWER_FAULT(src[1]), .PROG_DAMAGED(src[2]), .MEM_DENIED(src[3]),
    .SYSPROG_ERR(src[4]), .WARN_ERR(src[5]), .ID_MISMATCH(src[6]),
    .PWD_MISMATCH(src[7]), .SILENT_WARN(src[8]), .DL_FAULT(src[9]),
    .DL_KIND(dl_kind), .DL_CODE(dl_code), .WARN_EN(warn_en),
    .SILENT_EN(silent_en), .ERR_CLEAR(clr), .ERROR_LED(led),
    .CPU_RUN(run), .ERROR_CODE(code), .ERROR_VALID(valid),
    .SPECIAL_AUX_RELAY(aux), .SPECIAL_DATA_REG(dreg));

  always #4 clk = ~clk;

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp1(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s %h", $time, m, got);
    end
  endtask

  // One-cycle source pulse; returns once the answer has landed
  task automatic hit(input logic [9:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= '0;
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clear;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    cmp1(run, 1'b1, "run after clear");
    cmp1(valid, 1'b0, "valid after clear");
    tick(1);
    cmp1(led, 1'b0, "led after clear");
  endtask

  task automatic sc_halts;
    logic [9:0]  bits[4] = '{10'h004, 10'h008, 10'h010, 10'h002};
    logic [15:0] exp[4] = '{CODE_PROG_DMG, CODE_MEM_DENY, 16'h0000,
                            16'h0000};
    for (int i = 0; i < 4; i++) begin
      hit(bits[i]);
      cmp1(run, 1'b0, "halt");
      cmp16(code, exp[i], "halt code");
      cmp1(valid, 1'b1, "valid");
      tick(1);
      cmp1(led, 1'b1, "blink starts lit");
      tick(150);
      cmp1(led, 1'b1, "no early toggle");
      cmp1(run, 1'b0, "still halted");
      cmp16(code, exp[i], "code held");
      clear();
    end
  endtask

  task automatic sc_serious;
    hit(10'h01F);
    cmp16(code, CODE_SCAN_TO, "serious code");
    cmp1(run, 1'b0, "serious halt");
    for (int i = 0; i < 100; i++) begin
      tick(1);
      cmp1(led, 1'b1, "steady on");
    end
    clear();
  endtask

  task automatic sc_quiet;
    hit(10'h040);
    cmp16(code, CODE_ID_BAD, "id code");
    hit(10'h080);
    cmp16(code, CODE_ID_BAD, "id outranks pwd");
    cmp1(run, 1'b1, "keeps running");
    tick(1);
    cmp1(led, 1'b0, "led off");
    clear();
    hit(10'h080);
    cmp16(code, CODE_PWD_BAD, "pwd code");
    clear();
  endtask

  task automatic sc_download;
    logic [1:0]  k[6] = '{DL_SYNTAX, DL_EXE_LEN, DL_SRC_LEN, DL_OTHER,
                          DL_OTHER, DL_OTHER};
    logic [15:0] c[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h8ABC,
                          16'h1234, 16'h8000};
    logic [15:0] e[6] = '{CODE_SYNTAX, CODE_EXE_LEN, CODE_SRC_LEN,
                          16'h8ABC, CODE_SW_HI, CODE_SW_LO};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      dl_kind <= k[i];
      dl_code <= c[i];
      hit(10'h200);
      cmp16(code, e[i], "download code");
      clear();
    end
  endtask

  task automatic sc_warn;
    hit(10'h120);
    cmp16(dreg, 16'h0000, "disabled warnings ignored");
    cmp1(aux, 1'b0, "no flag");
    @(posedge clk);
    warn_en <= 1'b1;
    hit(10'h020);
    cmp1(aux, 1'b1, "warn flag");
    cmp1(run, 1'b1, "warn runs");
    tick(1);
    cmp1(led, 1'b1, "slow starts lit");
    tick(100);
    cmp1(led, 1'b1, "slow still lit");
    clear();
    @(posedge clk);
    silent_en <= 1'b1;
    hit(10'h100);
    cmp16(dreg, 16'h0100, "silent bit");
    cmp1(run, 1'b1, "silent runs");
    tick(1);
    cmp1(led, 1'b0, "silent dark");
    clear();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("CHECK FAILED at %0t: timeout", $time);
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    #1;
    cmp1(led, 1'b0, "reset led");
    cmp1(run, 1'b1, "reset run");
    cmp16(code, CODE_NONE, "reset code");
    sc_halts();
    sc_serious();
    sc_quiet();
    sc_download();
    sc_warn();
    test_done();
  end
endmodule
